// *** spp_far_slave.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// behavioural far-end serial peripheral for master transfers
module spp_far_slave (
	// frame set-up from the bench
	input wire logic load,
	input wire logic clock_phase_bit,
	input wire logic bit_order_bit,
	input wire logic [7:0] sendByte,
	// serial pins
	input wire logic sclk,
	input wire logic mosi,
	output logic miso,
	// results of the last frame
	output logic [7:0] gotByte,
	output int edges,
	output realtime span
);
	realtime firstAt; // time of first clock edge
	int k; // bit index of the current edge
	// idle until armed
	initial begin
		edges = 16;
		miso = 1'b0;
		span = 0.0;
	end
	// outgoing bit in wire order
	function automatic logic pick(input int n);
		return bit_order_bit ? sendByte[n] : sendByte[7-n];
	endfunction : pick
	// arm a frame, first bit ahead of the first edge in phase 0
	always @(posedge load) begin
		edges = 0;
		gotByte = 8'h00;
		if (!clock_phase_bit) miso = pick(0);
	end
	// count edges, sample on one kind and shift on the other
	always @(sclk) begin
		if (edges < 16) begin
			edges = edges + 1;
			k = (edges - 1) / 2;
			if (edges == 1) firstAt = $realtime;
			if (edges == 16) span = $realtime - firstAt;
			if ((edges % 2 == 1) == !clock_phase_bit) gotByte[bit_order_bit ? k : 7 - k] = mosi;
			else if (edges < 16) miso = pick(clock_phase_bit ? k : k + 1);
			// released line shows no stale bit
			if (edges == 16) miso = ~miso;
		end
	end
endmodule : spp_far_slave

// *** spp_pkg.sv ***
////////////////////////////////////////////////////////////////////////////////
// shared constants of the serial port block
package spp_pkg;

	// bus geometry
	localparam int ADDR_W = 12; // byte address width of the register window
	localparam int DATA_W = 32; // bus data width

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL = 8'hbc; // serial_port_control
	localparam logic [7:0] IDX_STATUS = 8'hbd; // serial_port_status
	localparam logic [7:0] IDX_DATA = 8'hbe; // serial_data_register
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hbf; // sticky event bits, write one to clear
	localparam logic [7:0] IDX_IRQ_MASK = 8'hc0; // event enables

	// byte addresses derived from the indices
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'h0, IDX_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_DATA = {2'h0, IDX_DATA, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};

	// control field positions
	localparam int CTL_ENABLE = 7; // port_enable_bit
	localparam int CTL_MASTER = 6; // master_select_bit
	localparam int CTL_CLOCK_POLARITY_BIT = 5; // clock_polarity_bit
	localparam int CTL_CLOCK_PHASE_BIT = 4; // clock_phase_bit
	localparam int CTL_SELECT_PIN_IGNORE_BIT = 3; // select_pin_ignore_bit
	localparam int CTL_BIT_ORDER_BIT = 2; // bit_order_bit
	localparam int CTL_RATE_HI = 1; // clock_rate_field upper bit
	localparam int CTL_RATE_LO = 0; // clock_rate_field lower bit

	// status field positions
	localparam int STA_DONE = 7; // transfer complete
	localparam int STA_WCOL = 6; // write collision
	localparam int STA_MODF = 5; // mode fault
	localparam int STA_OVR = 4; // receive overrun
	localparam int STA_RXFULL = 3; // receive_full_flag
	localparam int STA_BUSY = 0; // transfer_busy_flag

	// interrupt event positions
	localparam int IRQ_DONE = 0;
	localparam int IRQ_WCOL = 1;
	localparam int IRQ_MODF = 2;
	localparam int IRQ_OVR = 3;
	localparam int IRQ_W = 4;

	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;
	localparam logic [7:0] TX_RESET = 8'h00;

	// serial timing: two clock edges per bit, eight bits per byte
	localparam int EDGES_PER_BYTE = 16;
	localparam logic [3:0] LAST_EDGE = 4'(EDGES_PER_BYTE - 1);

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : spp_pkg

// *** spp_port.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// serial port controller with its register slave
module spp_port (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register bus write address
	input wire logic [spp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// register bus write data
	input wire logic [spp_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// register bus write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// register bus read
	input wire logic [spp_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [spp_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial clock pin
	input wire logic sclkIn,
	output logic sclkOut,
	output logic sclkOe,
	// master-out data pin
	input wire logic mosiIn,
	output logic mosiOut,
	output logic mosiOe,
	// master-in data pin
	input wire logic misoIn,
	output logic misoOut,
	output logic misoOe,
	// slave select pin
	input wire logic selectInN,
	// interrupt
	input wire logic vectorAck,
	output logic irq
);

	// all controller state
	typedef struct packed {
		logic [7:0] ctrl; // control register
		logic doneF; // transfer complete
		logic wcolF; // write collision
		logic modfF; // mode fault
		logic ovrF; // receive overrun
		logic rxFullF; // receive buffer full
		logic [7:0] txHold; // byte waiting to go out
		logic [spp_pkg::IRQ_W-1:0] irqStat; // sticky events
		logic [spp_pkg::IRQ_W-1:0] irqMask; // event enables
		logic [3:0] divCnt; // half period counter
		logic sclk; // master clock level
		logic sclkS1; // pin synchronisers
		logic sclkS2;
		logic sclkPrev;
		logic mosiS1;
		logic mosiS2;
		logic misoS1;
		logic misoS2;
		logic ssS1;
		logic ssS2;
		logic awHeld; // write address captured
		logic [spp_pkg::ADDR_W-1:0] awAddr;
		logic wHeld; // write data captured
		logic [7:0] wData;
		logic wStrb0;
		logic bvalid; // write response pending
		logic [1:0] bresp;
		logic rvalid; // read data pending
		logic [7:0] rdata;
		logic [1:0] rresp;
	} spp_port_state_t;

	spp_port_state_t st;
	spp_port_state_t next_st;
	spp_shift_if sh ();

	// decoded controls
	logic en;
	logic master;
	logic select_pin_ignore_bit;
	logic [1:0] rate;
	logic ssActive; // select pin low
	logic selected; // slave addressed
	logic modeFault; // fault condition seen
	logic slaveEdge; // edge on incoming clock
	logic [3:0] halfLimit; // cycles per half period
	logic divTick; // master clock edge
	logic busyFlag; // reported busy
	logic wrDo; // write performed this cycle
	logic rdDo; // read taken this cycle
	logic dataWrite; // accepted data register write
	logic dataWriteOk; // data write while idle
	localparam int IRQ_W_L = spp_pkg::IRQ_W;
	logic [IRQ_W_L-1:0] irqSet; // events this cycle

	////////////////////////////////////////////////////////////////////////////
	// shift engine
	spp_shift_engine u_engine (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sh(sh)
	);

	////////////////////////////////////////////////////////////////////////////
	// decode and serial control
	always_comb begin
		en = st.ctrl[spp_pkg::CTL_ENABLE];
		master = st.ctrl[spp_pkg::CTL_MASTER];
		select_pin_ignore_bit = st.ctrl[spp_pkg::CTL_SELECT_PIN_IGNORE_BIT];
		rate = st.ctrl[spp_pkg::CTL_RATE_HI:spp_pkg::CTL_RATE_LO];
		ssActive = !st.ssS2;
		// slave answers only when chosen, unless the pin is ignored
		selected = en && !master && (select_pin_ignore_bit || ssActive);
		modeFault = en && master && !select_pin_ignore_bit && ssActive;
		slaveEdge = st.sclkS2 != st.sclkPrev;
		// half period of 1,2,4,8 cycles gives /2,/4,/8,/16
		halfLimit = 4'h1 << rate;
		divTick = master && sh.busy && (st.divCnt == halfLimit - 4'h1);
		busyFlag = master ? sh.busy : sh.started;
		wrDo = st.awHeld && st.wHeld && !st.bvalid;
		rdDo = s_axi_arvalid && !st.rvalid;
		dataWrite = wrDo && st.wStrb0 && (st.awAddr == spp_pkg::ADDR_DATA);
		dataWriteOk = dataWrite && !busyFlag;
		// engine controls
		sh.clock_phase_bit = st.ctrl[spp_pkg::CTL_CLOCK_PHASE_BIT];
		sh.bit_order_bit = st.ctrl[spp_pkg::CTL_BIT_ORDER_BIT];
		sh.abort = !en || modeFault || (!master && !selected);
		sh.edgeTick = master ? divTick : (selected && slaveEdge);
		sh.sampleIn = master ? st.misoS2 : st.mosiS2;
		sh.txByte = dataWriteOk ? st.wData : st.txHold;
		if (master) begin
			sh.load = dataWriteOk && en;
		end else begin
			// slave arms itself, reloads if software refreshes the byte
			sh.load = selected && ((!sh.busy && !sh.done) || dataWriteOk);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// next state: bus slave, registers, flags, divider, synchronisers
	always_comb begin
		next_st = st;
		irqSet = '0;
		// pin synchronisers
		next_st.sclkS1 = sclkIn;
		next_st.sclkS2 = st.sclkS1;
		next_st.sclkPrev = st.sclkS2;
		next_st.mosiS1 = mosiIn;
		next_st.mosiS2 = st.mosiS1;
		next_st.misoS1 = misoIn;
		next_st.misoS2 = st.misoS1;
		next_st.ssS1 = selectInN;
		next_st.ssS2 = st.ssS1;

		// divider restarts with every byte
		if (!sh.busy || divTick) begin
			next_st.divCnt = 4'h0;
		end else begin
			next_st.divCnt = st.divCnt + 4'h1;
		end
		// master clock idles at the polarity level
		if (!master || !sh.busy) begin
			next_st.sclk = st.ctrl[spp_pkg::CTL_CLOCK_POLARITY_BIT];
		end else if (divTick) begin
			next_st.sclk = !st.sclk;
		end

		// write address and data channels, taken in either order
		if (s_axi_awvalid && !st.awHeld) begin
			next_st.awHeld = 1'b1;
			next_st.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st.wHeld) begin
			next_st.wHeld = 1'b1;
			next_st.wData = s_axi_wdata[7:0];
			next_st.wStrb0 = s_axi_wstrb[0];
		end
		// write response handshake
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		// perform the write once both halves are in
		if (wrDo) begin
			next_st.awHeld = 1'b0;
			next_st.wHeld = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = spp_pkg::RESP_OKAY;
			unique case (st.awAddr)
				spp_pkg::ADDR_CONTROL: begin
					if (st.wStrb0) begin
						next_st.ctrl = st.wData;
					end
				end
				spp_pkg::ADDR_STATUS: begin
					// writing zero clears a flag, one leaves it
					if (st.wStrb0) begin
						if (!st.wData[spp_pkg::STA_DONE]) next_st.doneF = 1'b0;
						if (!st.wData[spp_pkg::STA_WCOL]) next_st.wcolF = 1'b0;
						if (!st.wData[spp_pkg::STA_MODF]) next_st.modfF = 1'b0;
						if (!st.wData[spp_pkg::STA_OVR]) next_st.ovrF = 1'b0;
						if (!st.wData[spp_pkg::STA_RXFULL]) next_st.rxFullF = 1'b0;
					end
				end
				spp_pkg::ADDR_DATA: begin
					if (st.wStrb0) begin
						if (busyFlag) begin
							next_st.wcolF = 1'b1;
							irqSet[spp_pkg::IRQ_WCOL] = 1'b1;
						end else begin
							// fresh byte once idle also clears collision
							next_st.txHold = st.wData;
							next_st.wcolF = 1'b0;
						end
					end
				end
				spp_pkg::ADDR_IRQ_STATUS: begin
					if (st.wStrb0) begin
						next_st.irqStat = st.irqStat & ~st.wData[IRQ_W_L-1:0];
					end
				end
				spp_pkg::ADDR_IRQ_MASK: begin
					if (st.wStrb0) begin
						next_st.irqMask = st.wData[IRQ_W_L-1:0];
					end
				end
				default: begin
					// unmapped address
					next_st.bresp = spp_pkg::RESP_SLVERR;
				end
			endcase
		end

		// read channel
		if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		if (rdDo) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = spp_pkg::RESP_OKAY;
			next_st.rdata = 8'h00;
			unique case (s_axi_araddr)
				spp_pkg::ADDR_CONTROL: begin
					next_st.rdata = st.ctrl;
				end
				spp_pkg::ADDR_STATUS: begin
					next_st.rdata = {st.doneF, st.wcolF, st.modfF, st.ovrF, st.rxFullF,
						2'h0, busyFlag};
				end
				spp_pkg::ADDR_DATA: begin
					// reading the byte empties the buffer
					next_st.rdata = sh.rxByte;
					next_st.rxFullF = 1'b0;
					next_st.ovrF = 1'b0;
				end
				spp_pkg::ADDR_IRQ_STATUS: begin
					next_st.rdata = {4'h0, st.irqStat};
				end
				spp_pkg::ADDR_IRQ_MASK: begin
					next_st.rdata = {4'h0, st.irqMask};
				end
				default: begin
					next_st.rresp = spp_pkg::RESP_SLVERR;
				end
			endcase
		end

		// vectoring clears the done flag
		if (vectorAck) begin
			next_st.doneF = 1'b0;
		end

		// hardware sets come last so they win over clears
		if (sh.done) begin
			next_st.doneF = 1'b1;
			irqSet[spp_pkg::IRQ_DONE] = 1'b1;
			if (st.rxFullF) begin
				next_st.ovrF = 1'b1;
				irqSet[spp_pkg::IRQ_OVR] = 1'b1;
			end
			next_st.rxFullF = 1'b1;
		end
		if (modeFault) begin
			next_st.modfF = 1'b1;
			irqSet[spp_pkg::IRQ_MODF] = 1'b1;
			next_st.ctrl[spp_pkg::CTL_ENABLE] = 1'b0;
			next_st.ctrl[spp_pkg::CTL_MASTER] = 1'b0;
		end
		next_st.irqStat = next_st.irqStat | irqSet;
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.ctrl <= spp_pkg::CONTROL_RESET;
			st.txHold <= spp_pkg::TX_RESET;
			st.irqMask <= spp_pkg::IRQ_MASK_RESET;
			st.sclkS1 <= 1'b1;
			st.sclkS2 <= 1'b1;
			st.sclkPrev <= 1'b1;
			st.ssS1 <= 1'b1;
			st.ssS2 <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign s_axi_awready = !st.awHeld;
	assign s_axi_wready = !st.wHeld;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = {24'h000000, st.rdata};
	assign s_axi_rresp = st.rresp;
	// master drives clock and data out, slave drives data in
	assign sclkOut = st.sclk;
	assign sclkOe = en && master;
	assign mosiOut = sh.outBit;
	assign mosiOe = en && master;
	assign misoOut = sh.outBit;
	assign misoOe = selected;
	// level interrupt from unmasked sticky events
	assign irq = |(st.irqStat & st.irqMask);

endmodule : spp_port

// *** spp_port_sva.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// port-level checks of the serial port
module spp_port_sva (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// register bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [spp_pkg::DATA_W-1:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pin enables and interrupt
	input wire logic sclkOe,
	input wire logic mosiOe,
	input wire logic misoOe,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////////////////////////////////////////////
	// bus behaviour
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	read_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
		else $error("read address ready wrong");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	addr_refuse_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second address taken");
	data_refuse_a: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
		else $error("second data taken");
	resp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
		else $error("bad write response code");
	rdata_byte_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("read data upper bits set");
	////////////////////////////////////////////////////////////////////////////////
	// role and pins
	role_pins_a: assert property (!(mosiOe && misoOe))
		else $error("master and slave drivers both on");
	master_pins_a: assert property (sclkOe == mosiOe)
		else $error("clock and data drivers disagree");
	// main scenarios reached
	cover property ($fell(sclkOe));
	cover property ($rose(irq));
	cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
endmodule : spp_port_sva

// *** spp_shift_engine.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// byte shifter driven by serial clock edge ticks
module spp_shift_engine (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// controller link
	spp_shift_if.engine sh
);

	// all engine state
	typedef struct packed {
		logic busy; // armed or shifting
		logic [3:0] cnt; // edges seen in this byte
		logic [7:0] sr; // shift register, out and in share it
		logic outBit; // bit on the data line
		logic done; // byte finished pulse
		logic [7:0] rx; // captured byte
	} spp_engine_state_t;

	spp_engine_state_t st;
	spp_engine_state_t next_st;
	logic sampleEdge; // this edge samples
	logic [7:0] shiftedSr; // register after taking the sampled bit

	////////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		// even edges lead, odd edges trail
		sampleEdge = (st.cnt[0] == sh.clock_phase_bit);
		if (sh.bit_order_bit) begin
			shiftedSr = {sh.sampleIn, st.sr[7:1]};
		end else begin
			shiftedSr = {st.sr[6:0], sh.sampleIn};
		end
		if (sh.abort) begin
			// disable, deselect or fault
			next_st.busy = 1'b0;
			next_st.cnt = 4'h0;
		end else if (sh.load) begin
			// first bit is on the line before any edge
			next_st.sr = sh.txByte;
			next_st.outBit = sh.bit_order_bit ? sh.txByte[0] : sh.txByte[7];
			next_st.busy = 1'b1;
			next_st.cnt = 4'h0;
		end else if (st.busy && sh.edgeTick) begin
			next_st.cnt = st.cnt + 4'h1;
			if (sampleEdge) begin
				next_st.sr = shiftedSr;
			end else begin
				next_st.outBit = sh.bit_order_bit ? st.sr[0] : st.sr[7];
			end
			// last edge closes the byte
			if (st.cnt == spp_pkg::LAST_EDGE) begin
				next_st.busy = 1'b0;
				next_st.cnt = 4'h0;
				next_st.done = 1'b1;
				next_st.rx = sampleEdge ? shiftedSr : st.sr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign sh.busy = st.busy;
	assign sh.started = st.busy && (st.cnt != 4'h0);
	assign sh.outBit = st.outBit;
	assign sh.done = st.done;
	assign sh.rxByte = st.rx;

endmodule : spp_shift_engine

// *** spp_shift_if.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// link between the port controller and its shift engine
interface spp_shift_if;
	logic clock_phase_bit; // sample on second edge when high
	logic bit_order_bit; // least significant bit first when high
	logic load; // load txByte and arm the engine
	logic abort; // drop any transfer at once
	logic edgeTick; // one serial clock edge happened
	logic sampleIn; // incoming data bit
	logic [7:0] txByte; // byte to send
	logic busy; // armed or shifting
	logic started; // at least one edge seen
	logic outBit; // outgoing data bit
	logic done; // one-cycle pulse at byte end
	logic [7:0] rxByte; // last received byte

	// engine side
	modport engine (
		input clock_phase_bit, bit_order_bit, load, abort, edgeTick, sampleIn, txByte,
		output busy, started, outBit, done, rxByte
	);

	// controller side
	modport control (
		output clock_phase_bit, bit_order_bit, load, abort, edgeTick, sampleIn, txByte,
		input busy, started, outBit, done, rxByte
	);
endinterface : spp_shift_if

// *** test_spi_master_slave_port.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench of the serial port: master transfers, faults and slave pin drive
module test_spi_master_slave_port;
	// clock, reset and register bus
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [spp_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
	logic [spp_pkg::ADDR_W-1:0] s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [spp_pkg::DATA_W-1:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [spp_pkg::DATA_W-1:0] s_axi_rdata;
	// serial pins and interrupt
	logic sclkIn = 1'b0;
	logic mosiIn = 1'b0;
	logic selectInN = 1'b1;
	logic vectorAck = 1'b0;
	logic misoIn, sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, irq;
	// far-end set-up and results
	logic pLoad = 1'b0;
	logic pCpha = 1'b0;
	logic pLsbf = 1'b0;
	logic [7:0] pByte = 8'h00;
	logic [7:0] pGot;
	int pEdges;
	realtime pSpan;
	// bookkeeping
	int seed = 65896;
	int badCount = 0;
	int checksDone = 0;
	int cycles = 0;
	logic [31:0] rdv; // last read word
	logic [1:0] rsp; // last read response
	logic [7:0] tx, pb; // bytes sent by each end
	logic [1:0] rate;
	logic clock_polarity_bit, clock_phase_bit, bit_order_bit;

	spp_port i_dut (.*);
	spp_far_slave i_far (.load(pLoad), .clock_phase_bit(pCpha), .bit_order_bit(pLsbf), .sendByte(pByte),
		.sclk(sclkOut), .mosi(mosiOut), .miso(misoIn), .gotByte(pGot), .edges(pEdges),
		.span(pSpan));

	always #4 ref_clk = ~ref_clk;
	// hang guard
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			badCount++;
			giveVerdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// helpers
	task automatic check(input string what, input logic [31:0] seen, exp);
		checksDone++;
		if (seen !== exp) begin
			badCount++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// expected status byte
	function automatic logic [31:0] sta(input logic d, w, m, o, f);
		sta = 32'h0;
		sta[spp_pkg::STA_DONE] = d;
		sta[spp_pkg::STA_WCOL] = w;
		sta[spp_pkg::STA_MODF] = m;
		sta[spp_pkg::STA_OVR] = o;
		sta[spp_pkg::STA_RXFULL] = f;
	endfunction : sta
	// bus write, each channel released when taken
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic aw, w;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(negedge ref_clk);
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			@(posedge ref_clk);
			if (!aw) s_axi_awvalid <= 1'b0;
			if (!w) s_axi_wvalid <= 1'b0;
		end
		do @(negedge ref_clk); while (!s_axi_bvalid);
		@(posedge ref_clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	// bus read into rdv and rsp
	task automatic rd(input logic [11:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge ref_clk); while (!s_axi_arready);
		@(posedge ref_clk);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge ref_clk);
			rdv = s_axi_rdata;
			rsp = s_axi_rresp;
		end while (!s_axi_rvalid);
		@(posedge ref_clk);
		s_axi_rready <= 1'b0;
	endtask : rd
	// one master byte: control, arm far end, send, wait for frame end
	task automatic xfer(input logic [7:0] ctl, input logic twice);
		int n;
		wr(spp_pkg::ADDR_CONTROL, ctl);
		// idle clock level moves one cycle after the control write
		@(posedge ref_clk);
		pCpha <= ctl[spp_pkg::CTL_CLOCK_PHASE_BIT];
		pLsbf <= ctl[spp_pkg::CTL_BIT_ORDER_BIT];
		pByte <= pb;
		pLoad <= 1'b1;
		@(posedge ref_clk);
		pLoad <= 1'b0;
		wr(spp_pkg::ADDR_DATA, tx);
		if (twice) begin
			wr(spp_pkg::ADDR_DATA, ~tx);
			rd(spp_pkg::ADDR_STATUS);
			check("busy mid byte", 32'(rdv[spp_pkg::STA_BUSY]), 32'h1);
			check("collision mid byte", 32'(rdv[spp_pkg::STA_WCOL]), 32'h1);
		end
		for (n = 0; n < 600 && pEdges < 16; n++) @(posedge ref_clk);
		@(posedge ref_clk);
	endtask : xfer
	task automatic endTest(input string name);
		$display("test %s finished", name);
	endtask : endTest
	task automatic giveVerdict();
		$display("checks %0d mismatches %0d", checksDone, badCount);
		if (badCount == 0 && checksDone > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : giveVerdict
	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(spp_pkg::ADDR_CONTROL);
		check("control reset", rdv, 32'(spp_pkg::CONTROL_RESET));
		rd(spp_pkg::ADDR_STATUS);
		check("status reset", rdv, 32'h0);
		rd(spp_pkg::ADDR_IRQ_MASK);
		check("mask reset", rdv, 32'(spp_pkg::IRQ_MASK_RESET));
		rd(12'h000);
		check("unmapped resp", 32'(rsp), 32'(spp_pkg::RESP_SLVERR));
		check("unmapped data", rdv, 32'h0);
		endTest("reset values");
		// random modes over every rate code
		wr(spp_pkg::ADDR_IRQ_MASK, 8'h0f);
		for (int i = 0; i < 8; i++) begin
			rate = 2'(i);
			clock_polarity_bit = 1'($random(seed));
			clock_phase_bit = 1'($random(seed));
			bit_order_bit = 1'($random(seed));
			tx = 8'($random(seed));
			pb = 8'($random(seed));
			xfer({2'h3, clock_polarity_bit, clock_phase_bit, 1'b0, bit_order_bit, rate}, 1'b0);
			check("mosi byte", 32'(pGot), 32'(tx));
			check("clock span", 32'(int'(pSpan)), 32'(120 << rate));
			check("idle clock", 32'(sclkOut), 32'(clock_polarity_bit));
			rd(spp_pkg::ADDR_STATUS);
			check("status after byte", rdv, sta(1, 0, 0, 0, 1));
			check("irq on done", 32'(irq), 32'h1);
			rd(spp_pkg::ADDR_DATA);
			// two-stage input sync needs half periods of three cycles or more
			if (rate > 2'h1) check("rx byte", rdv, 32'(pb));
			rd(spp_pkg::ADDR_STATUS);
			check("rx full cleared", rdv, sta(1, 0, 0, 0, 0));
			wr(spp_pkg::ADDR_STATUS, 8'h00);
			wr(spp_pkg::ADDR_IRQ_STATUS, 8'h0f);
			rd(spp_pkg::ADDR_STATUS);
			check("flags cleared", rdv, 32'h0);
			check("irq cleared", 32'(irq), 32'h0);
		end
		endTest("random bytes");
		// collision during a byte that also overruns
		tx = 8'ha5;
		pb = 8'h3c;
		xfer(8'hc2, 1'b0);
		tx = 8'h96;
		pb = 8'h5a;
		xfer(8'hc2, 1'b1);
		check("collided byte", 32'(pGot), 32'h96);
		rd(spp_pkg::ADDR_STATUS);
		check("overrun status", rdv, sta(1, 1, 0, 1, 1));
		rd(spp_pkg::ADDR_IRQ_STATUS);
		check("event bits", rdv, 32'hb);
		rd(spp_pkg::ADDR_DATA);
		check("latest byte", rdv, 32'h5a);
		rd(spp_pkg::ADDR_STATUS);
		check("overrun cleared", rdv, sta(1, 1, 0, 0, 0));
		tx = 8'h11;
		xfer(8'hc2, 1'b0);
		rd(spp_pkg::ADDR_STATUS);
		check("collision cleared", rdv, sta(1, 0, 0, 0, 1));
		vectorAck <= 1'b1;
		@(posedge ref_clk);
		vectorAck <= 1'b0;
		rd(spp_pkg::ADDR_STATUS);
		check("vectored done", rdv, sta(0, 0, 0, 0, 1));
		wr(spp_pkg::ADDR_STATUS, 8'h00);
		wr(spp_pkg::ADDR_IRQ_STATUS, 8'h0f);
		endTest("collision and overrun");
		// select pin ignored, then honoured
		wr(spp_pkg::ADDR_CONTROL, 8'hc8);
		selectInN <= 1'b0;
		repeat (8) @(posedge ref_clk);
		rd(spp_pkg::ADDR_STATUS);
		check("select ignored", rdv, 32'h0);
		wr(spp_pkg::ADDR_CONTROL, 8'hc0);
		repeat (8) @(posedge ref_clk);
		rd(spp_pkg::ADDR_STATUS);
		check("mode fault", rdv, sta(0, 0, 1, 0, 0));
		rd(spp_pkg::ADDR_CONTROL);
		check("role dropped", rdv, 32'h0);
		check("irq on fault", 32'(irq), 32'h1);
		wr(spp_pkg::ADDR_IRQ_MASK, 8'h00);
		check("irq masked", 32'(irq), 32'h0);
		wr(spp_pkg::ADDR_IRQ_MASK, 8'h0f);
		wr(spp_pkg::ADDR_IRQ_STATUS, 8'h04);
		check("irq event cleared", 32'(irq), 32'h0);
		wr(spp_pkg::ADDR_STATUS, 8'h00);
		rd(spp_pkg::ADDR_STATUS);
		check("fault cleared", rdv, 32'h0);
		selectInN <= 1'b1;
		// disabled port ignores data
		wr(spp_pkg::ADDR_DATA, 8'h77);
		repeat (40) @(posedge ref_clk);
		rd(spp_pkg::ADDR_STATUS);
		check("disabled port idle", rdv, 32'h0);
		// enabled slave drives its data pin once selected
		wr(spp_pkg::ADDR_CONTROL, 8'h80);
		selectInN <= 1'b0;
		repeat (4) @(posedge ref_clk);
		check("slave drives", 32'(misoOe), 32'h1);
		check("slave no clock", 32'(sclkOe), 32'h0);
		endTest("mode fault and disable");
		giveVerdict();
	end
endmodule : test_spi_master_slave_port

bind spp_port spp_port_sva i_sva (.*);
